// ==== hdl/adsq_ctrl.sv ====
/*
  adsq_ctrl.sv - sequencing control of the analog-to-digital converter:
  start, trigger, mode sequencing, result storage, completion flag, abort.
  assumes: one 100 MHz clock; analog sample values arrive as parallel
  data from the converter core; configuration is held by the host.
*/
// Functional notes
// R1 - host changes the three control words only while stopped, except start.
// R2 - host waits 1 us after connecting the reference before starting.
// R3 - host keeps direction of every analog input pin at input.
// R4 - with external trigger selected the trigger pin stays an input.
// R5 - a low level on an upper analog pin raises a key interrupt.
// R6 - host keeps the conversion clock within 250 kHz/1 MHz to 10 MHz.
// R7 - host rewrites channel and sweep select after any mode change.
// R8 - a read of a result register coinciding with its own store is flagged as a hazard.
// R9 - completion sets the interrupt request flag for polling.
// R10 - in one-shot and single sweep the host waits for completion.
// R11 - in repeat modes the host runs the cpu on the undivided clock.
// R12 - clearing start mid-conversion aborts and spoils every result.
// R13 - host disables the interrupt before aborting a single sweep.
// R14 - setting start converts at once or on the next trigger edge.
`timescale 1ns/1ps
`default_nettype none
`include "adsq_cfg.svh"
module adsq_ctrl (
  input  wire logic                     CLK_SYS,
  input  wire logic                     RESET,
  input  wire logic                     CONVERSION_START,
  input  wire logic                     TRIGGER_SELECT,
  input  wire logic                     EXTERNAL_TRIGGER_PIN,
  input  wire logic                     REFERENCE_CONNECT,
  input  wire adsq_pkg::adsq_mode_type  MODE,
  input  wire logic [2:0]               CHANNEL_SELECT,
  input  wire logic [1:0]               SWEEP_SELECT,
  input  wire logic [7:0]               CONV_CLK_DIV,
  input  wire logic                     KEY_INT_ENABLE,
  input  wire logic [3:0]               UPPER_ANALOG_PINS,
  input  wire adsq_pkg::adsq_result_type SAMPLE_DATA,
  input  wire logic                     RESULT_READ,
  input  wire logic [2:0]               RESULT_READ_SEL,
  input  wire logic                     IRQ_FLAG_CLEAR,
  output var  adsq_pkg::adsq_result_type RESULT_DATA,
  output var  logic [2:0]               SAMPLE_CHANNEL,
  output var  logic                     INTERRUPT_REQUEST_FLAG,
  output var  logic                     KEY_INTERRUPT,
  output var  logic                     BUSY,
  output var  logic                     RESULTS_INVALID,
  output var  logic                     READ_HAZARD,
  output var  logic                     REFERENCE_READY
);
  import adsq_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_ARMED, S_CONV} adsq_state_type;

  adsq_state_type  state_reg, state_next;
  logic [2:0]      ch_reg, ch_next, last_ch_reg, last_ch_next;
  logic [7:0]      tick_cnt_reg, tick_cnt_next;
  logic [9:0]      settle_reg, settle_next;
  logic            irq_next, inv_next, haz_next, refrdy_next, busy_next;
  logic            start_d_reg, ref_d_reg;
  logic [2:0]      trg_sync_reg;
  logic            trg_level_reg, trg_level_next;
  logic [3:0]      key_s1_reg, key_s2_reg, key_s3_reg;
  logic [3:0]      key_lvl_reg, key_lvl_next;
  logic            key_next;
  adsq_result_type result_reg [`ADSQ_NUM_CH];
  adsq_result_type rd_next;
  logic            store;
  logic            conv_tick;
  logic            trig_edge;

  adsq_clkdiv u_div (
    .clk  (CLK_SYS),
    .rst  (RESET),
    .run  (state_reg == S_CONV),
    .div  (CONV_CLK_DIV),
    .tick (conv_tick)
  );

  // pin synchronisers: three stages, change accepted when stages 2 and 3 agree
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      trg_sync_reg <= 3'h7;
      key_s1_reg   <= 4'hf;
      key_s2_reg   <= 4'hf;
      key_s3_reg   <= 4'hf;
    end else begin
      trg_sync_reg <= {trg_sync_reg[1:0], EXTERNAL_TRIGGER_PIN};
      key_s1_reg   <= UPPER_ANALOG_PINS;
      key_s2_reg   <= key_s1_reg;
      key_s3_reg   <= key_s2_reg;
    end
  end

  // filtered levels and the falling trigger edge used to start
  always_comb begin
    trg_level_next = trg_level_reg;
    if (trg_sync_reg[1] == trg_sync_reg[2]) begin
      trg_level_next = trg_sync_reg[2];
    end
    trig_edge = trg_level_reg && !trg_level_next;
    for (int i = 0; i < 4; i++) begin
      key_lvl_next[i] = key_lvl_reg[i];
      if (key_s2_reg[i] == key_s3_reg[i]) begin
        key_lvl_next[i] = key_s3_reg[i];
      end
    end
    // key interrupt fires on any upper pin going low
    key_next = KEY_INT_ENABLE && |(key_lvl_reg & ~key_lvl_next); // [R5]
  end

  // settle counter restarts when the reference is connected
  always_comb begin
    settle_next = settle_reg;
    if (!REFERENCE_CONNECT) begin
      settle_next = 10'h000;
    end else if (!ref_d_reg) begin
      settle_next = 10'h000; // [R2]
    end else if (settle_reg != 10'(`ADSQ_SETTLE_CYC)) begin
      settle_next = settle_reg + 10'h001;
    end
    refrdy_next = REFERENCE_CONNECT && ref_d_reg &&
                  (settle_next == 10'(`ADSQ_SETTLE_CYC));
  end

  // sequencer: start, per-channel conversion, sweep and repeat, abort
  always_comb begin
    state_next    = state_reg;
    ch_next       = ch_reg;
    last_ch_next  = last_ch_reg;
    tick_cnt_next = tick_cnt_reg;
    inv_next      = RESULTS_INVALID;
    store         = 1'b0;
    case (state_reg)
      S_IDLE: begin
        if (CONVERSION_START && !start_d_reg) begin
          // sweep starts at channel 0; single modes use channel select
          if (MODE == ADSQ_ONE_SHOT || MODE == ADSQ_REPEAT) begin
            ch_next      = CHANNEL_SELECT;
            last_ch_next = CHANNEL_SELECT;
          end else begin
            ch_next      = 3'h0;
            last_ch_next = {SWEEP_SELECT, 1'b1};
          end
          tick_cnt_next = 8'h00;
          state_next = TRIGGER_SELECT ? S_ARMED : S_CONV; // [R14]
        end
      end
      S_ARMED: begin
        if (!CONVERSION_START) begin
          // dropping start while armed is an abort as well
          state_next = S_IDLE;
          inv_next   = 1'b1; // [R12]
        end else if (trig_edge) begin
          state_next = S_CONV; // [R14]
          inv_next   = 1'b0;
        end
      end
      S_CONV: begin
        inv_next = inv_next && !(ch_reg == 3'h0);
        if (!CONVERSION_START) begin
          // abort: every result is to be discarded
          state_next = S_IDLE;
          inv_next   = 1'b1; // [R12]
        end else if (conv_tick) begin
          if (tick_cnt_reg == `ADSQ_CONV_TICKS) begin
            store         = 1'b1;
            tick_cnt_next = 8'h00;
            if (ch_reg != last_ch_reg) begin
              ch_next = ch_reg + 3'h1;
            end else if (MODE == ADSQ_ONE_SHOT ||
                         MODE == ADSQ_SINGLE_SWEEP) begin
              state_next = S_IDLE;
            end else if (MODE != ADSQ_REPEAT) begin
              ch_next = 3'h0;
            end
          end else begin
            tick_cnt_next = tick_cnt_reg + 8'h01;
          end
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
    busy_next = state_next != S_IDLE;
    // completion flag: set wins over a clear in the same cycle
    irq_next = (INTERRUPT_REQUEST_FLAG && !IRQ_FLAG_CLEAR) || store; // [R9]
    // a read landing on the stored register in that same cycle is unsafe
    haz_next = RESULT_READ && store && (RESULT_READ_SEL == ch_reg); // [R8]
    rd_next  = RESULT_READ ? result_reg[RESULT_READ_SEL] : RESULT_DATA;
  end

  // result array: only the converted channel is written
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      for (int i = 0; i < `ADSQ_NUM_CH; i++) begin
        result_reg[i] <= `ADSQ_RESULT_RST;
      end
    end else if (store) begin
      result_reg[ch_reg] <= SAMPLE_DATA;
    end
  end

  // state registers
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      state_reg              <= S_IDLE;
      ch_reg                 <= 3'h0;
      last_ch_reg            <= 3'h0;
      tick_cnt_reg           <= 8'h00;
      settle_reg             <= 10'h000;
      start_d_reg            <= 1'b0;
      ref_d_reg              <= 1'b0;
      trg_level_reg          <= 1'b1;
      key_lvl_reg            <= 4'hf;
      RESULT_DATA            <= `ADSQ_RESULT_RST;
      SAMPLE_CHANNEL         <= 3'h0;
      INTERRUPT_REQUEST_FLAG <= 1'b0;
      KEY_INTERRUPT          <= 1'b0;
      BUSY                   <= 1'b0;
      RESULTS_INVALID        <= 1'b0;
      READ_HAZARD            <= 1'b0;
      REFERENCE_READY        <= 1'b0;
    end else begin
      state_reg              <= state_next;
      ch_reg                 <= ch_next;
      last_ch_reg            <= last_ch_next;
      tick_cnt_reg           <= tick_cnt_next;
      settle_reg             <= settle_next;
      start_d_reg            <= CONVERSION_START;
      ref_d_reg              <= REFERENCE_CONNECT;
      trg_level_reg          <= trg_level_next;
      key_lvl_reg            <= key_lvl_next;
      RESULT_DATA            <= rd_next;
      SAMPLE_CHANNEL         <= ch_next;
      INTERRUPT_REQUEST_FLAG <= irq_next;
      KEY_INTERRUPT          <= key_next;
      BUSY                   <= busy_next;
      RESULTS_INVALID        <= inv_next;
      READ_HAZARD            <= haz_next;
      REFERENCE_READY        <= refrdy_next;
    end
  end
endmodule : adsq_ctrl
`default_nettype wire

// ==== hdl/adsq_cfg.svh ====
/*
  adsq_cfg.svh - timing counts, field positions and reset values for the
  converter sequencing control.
  assumes: included by bare name from the design files of this block.
*/
`ifndef ADSQ_CFG_SVH
`define ADSQ_CFG_SVH

// system clock period in picoseconds (100 MHz)
`define ADSQ_CLK_PS          10000
// settle wait after reference connect, nanoseconds; cycles round up
`define ADSQ_SETTLE_NS       1000
`define ADSQ_SETTLE_CYC      ((`ADSQ_SETTLE_NS * 1000 + `ADSQ_CLK_PS - 1) / `ADSQ_CLK_PS)
// field positions inside the first control word
`define ADSQ_CTRL1_START_BIT 6
// conversion clock divider reset value and conversion length in conv clocks minus one
`define ADSQ_DIV_RST         8'h04
`define ADSQ_CONV_TICKS      8'h0e
// result reset value
`define ADSQ_RESULT_RST      10'h000
// number of analog channels and channel that starts the upper group
`define ADSQ_NUM_CH          8
`define ADSQ_UPPER_CH        4

`endif

// ==== hdl/adsq_pkg.sv ====
/*
  adsq_pkg.sv - types shared by the converter sequencing control.
  assumes: nothing beyond the compile order of the files.
*/
package adsq_pkg;
  // operating modes of the converter
  typedef enum logic [2:0] {
    ADSQ_ONE_SHOT,
    ADSQ_REPEAT,
    ADSQ_SINGLE_SWEEP,
    ADSQ_REPEAT_SWEEP0,
    ADSQ_REPEAT_SWEEP1
  } adsq_mode_type;

  typedef logic [9:0] adsq_result_type;
endpackage : adsq_pkg

// ==== hdl/adsq_clkdiv.sv ====
/*
  adsq_clkdiv.sv - divider making the one-cycle conversion clock enable.
  assumes: single system clock, asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module adsq_clkdiv (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [7:0] div,
  output var  logic       tick
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       tick_next;

  // count down while running; reload from div so changes take effect later
  always_comb begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!run) begin
      cnt_next = div;
    end else if (cnt_reg == 8'h00) begin
      cnt_next  = div;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg - 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 8'h00;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick    <= tick_next;
    end
  end
endmodule : adsq_clkdiv
`default_nettype wire

// ==== testbench/adsq_ctrl_assertions.sv ====
/*
  adsq_ctrl_assertions.sv - port checks for the sequencing control.
  assumes: bound onto adsq_ctrl; one clock, async active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module adsq_ctrl_checker (
  input wire logic                      CLK_SYS,
  input wire logic                      RESET,
  input wire logic                      CONVERSION_START,
  input wire logic                      TRIGGER_SELECT,
  input wire logic                      REFERENCE_CONNECT,
  input wire logic                      KEY_INT_ENABLE,
  input wire logic                      RESULT_READ,
  input wire logic                      IRQ_FLAG_CLEAR,
  input wire adsq_pkg::adsq_result_type RESULT_DATA,
  input wire logic                      INTERRUPT_REQUEST_FLAG,
  input wire logic                      KEY_INTERRUPT,
  input wire logic                      BUSY,
  input wire logic                      RESULTS_INVALID,
  input wire logic                      READ_HAZARD,
  input wire logic                      REFERENCE_READY
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // start edge while idle without trigger wait brings busy next cycle
  property p_busy_start;
    $rose(CONVERSION_START) && !BUSY && !TRIGGER_SELECT |=> BUSY;
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("busy did not follow start");
  // dropping start mid-run spoils results and stops the sequencer
  property p_abort;
    BUSY && !CONVERSION_START |-> ##[1:2] (RESULTS_INVALID && !BUSY);
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort not seen");
  // completion flag is sticky so a slow poller cannot miss it
  property p_flag_hold;
    INTERRUPT_REQUEST_FLAG && !IRQ_FLAG_CLEAR |=> INTERRUPT_REQUEST_FLAG;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("completion flag lost");
  property p_flag_cause;
    $rose(INTERRUPT_REQUEST_FLAG) |-> $past(BUSY);
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("completion flag without conversion");
  property p_key;
    KEY_INTERRUPT |-> $past(KEY_INT_ENABLE) ##1 !KEY_INTERRUPT;
  endproperty
  a_key: assert property (p_key)
    else $error("key pulse wrong");
  property p_ref_wait;
    $rose(REFERENCE_CONNECT) |=> !REFERENCE_READY [*8];
  endproperty
  a_ref_wait: assert property (p_ref_wait)
    else $error("reference ready too early");
  // edges seen with the reference connected, saturating at the top
  logic [7:0] ref_age_reg;
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ref_age_reg <= 8'h00;
    end else if (!REFERENCE_CONNECT) begin
      ref_age_reg <= 8'h00;
    end else if (ref_age_reg != 8'hff) begin
      ref_age_reg <= ref_age_reg + 8'h01;
    end
  end
  // ready may only come after a full microsecond of settling
  property p_ref_settle;
    $rose(REFERENCE_READY) |-> ref_age_reg >= 8'h65;
  endproperty
  a_ref_settle: assert property (p_ref_settle)
    else $error("reference ready before settle time");
  // read data must not move under the host between reads
  property p_read_hold;
    !RESULT_READ |=> $stable(RESULT_DATA);
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("read data moved without read");
  property p_hazard;
    READ_HAZARD |-> $past(RESULT_READ);
  endproperty
  a_hazard: assert property (p_hazard)
    else $error("hazard without read");
endmodule : adsq_ctrl_checker
bind adsq_ctrl adsq_ctrl_checker i_chk (.CLK_SYS(CLK_SYS), .RESET(RESET),
  .CONVERSION_START(CONVERSION_START), .TRIGGER_SELECT(TRIGGER_SELECT),
  .REFERENCE_CONNECT(REFERENCE_CONNECT), .KEY_INT_ENABLE(KEY_INT_ENABLE),
  .RESULT_READ(RESULT_READ), .IRQ_FLAG_CLEAR(IRQ_FLAG_CLEAR),
  .RESULT_DATA(RESULT_DATA), .INTERRUPT_REQUEST_FLAG(INTERRUPT_REQUEST_FLAG),
  .KEY_INTERRUPT(KEY_INTERRUPT), .BUSY(BUSY), .READ_HAZARD(READ_HAZARD),
  .RESULTS_INVALID(RESULTS_INVALID), .REFERENCE_READY(REFERENCE_READY));
`default_nettype wire

// ==== testbench/adsq_far_end.sv ====
/*
  adsq_far_end.sv - analog inputs, key pins and trigger source.
  assumes: bench commands trigger and key events by level.
*/
`timescale 1ns/1ps
`default_nettype none
module adsq_far_end (
  input  wire logic [2:0]                sample_channel,
  input  wire logic                      fire_trigger,
  input  wire logic                      press_key,
  output var  adsq_pkg::adsq_result_type sample_data,
  output var  logic                      trigger_pin,
  output var  logic [3:0]                key_pins
);
  // each channel reads a code naming it, so a wrong store shows up
  assign sample_data = {7'h2c, sample_channel};
  assign trigger_pin = !fire_trigger; // idles high, falls on command
  assign key_pins    = press_key ? 4'h7 : 4'hf; // top pin pulled low
endmodule : adsq_far_end
`default_nettype wire

// ==== testbench/adsq_ctrl_bench.sv ====
/*
  adsq_ctrl_bench.sv - self-checking bench for the sequencing control.
  assumes: adsq_far_end models the pins; inputs move at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module adsq_ctrl_bench;
  import adsq_pkg::*;
  logic clk = 0, rst = 1, start = 0, tsel = 0, refc = 0, key_en = 0;
  logic rd = 0, clr = 0, fire = 0, press = 0, trig, irq, key, busy, inv;
  logic haz, rdy;
  logic [2:0] ch = 3'h0, rsel = 3'h0, sch;
  logic [1:0] swp = 2'h0;
  logic [7:0] div = 8'h09; // 100 MHz / 10 gives a 10 MHz conv clock
  logic [3:0] kp;
  adsq_mode_type mode = ADSQ_ONE_SHOT;
  adsq_result_type samp, rdat, d;
  int bad_count = 0, tests_run = 0, hits;
  adsq_ctrl i_dut (.CLK_SYS(clk), .RESET(rst), .CONVERSION_START(start),
    .TRIGGER_SELECT(tsel), .EXTERNAL_TRIGGER_PIN(trig),
    .REFERENCE_CONNECT(refc), .MODE(mode), .CHANNEL_SELECT(ch),
    .SWEEP_SELECT(swp), .CONV_CLK_DIV(div), .KEY_INT_ENABLE(key_en),
    .UPPER_ANALOG_PINS(kp), .SAMPLE_DATA(samp), .RESULT_READ(rd),
    .RESULT_READ_SEL(rsel), .IRQ_FLAG_CLEAR(clr), .RESULT_DATA(rdat),
    .SAMPLE_CHANNEL(sch), .INTERRUPT_REQUEST_FLAG(irq), .KEY_INTERRUPT(key),
    .BUSY(busy), .RESULTS_INVALID(inv), .READ_HAZARD(haz),
    .REFERENCE_READY(rdy));
  adsq_far_end i_far (.sample_channel(sch),
    .fire_trigger(fire), .press_key(press), .sample_data(samp),
    .trigger_pin(trig), .key_pins(kp));
  initial forever #5 clk = ~clk;
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // bounded wait: 0 flag set, 1 sequencer idle, 2 key pulse
  task automatic wait_on(input int w);
    int n;
    n = 0;
    while (!(w == 0 ? irq === 1'b1 : w == 1 ? busy === 1'b0
             : key === 1'b1)) begin
      step(1);
      n++;
      // a four-channel sweep takes about 600 cycles at this clock
      if (n > 1000) begin
        bad_count++;
        end_of_test();
      end
    end
  endtask : wait_on
  // one read cycle; the extra edge keeps strobes from being reassigned
  task automatic read(input logic [2:0] s, output adsq_result_type v);
    rsel = s;
    rd = 1;
    step(1);
    rd = 0;
    v = rdat;
    step(1);
  endtask : read
  task automatic clear_irq;
    clr = 1;
    step(1);
    clr = 0;
    step(1);
  endtask : clear_irq
  initial begin
    step(16);
    rst = 0;
    `CHK({irq, busy, inv, rdy, key}, 5'h00)
    refc = 1;
    step(98);
    `CHK(rdy, 1'b0)
    step(6);
    `CHK(rdy, 1'b1)
    $display("test reference settle done");
    ch = 3'h3;
    start = 1;
    wait_on(0);
    `CHK(busy, 1'b0)
    start = 0;
    read(3'h3, d);
    `CHK(d, 10'h163)
    clear_irq();
    `CHK(irq, 1'b0)
    $display("test one-shot done");
    // mode changes only while stopped, channel and sweep rewritten
    mode = ADSQ_SINGLE_SWEEP;
    ch = 3'h0;
    swp = 2'h1;
    start = 1;
    step(2);
    wait_on(1);
    start = 0;
    for (int i = 0; i < 4; i++) begin
      read(i[2:0], d);
      `CHK(d, {7'h2c, i[2:0]})
    end
    `CHK(irq, 1'b1)
    clear_irq();
    $display("test single sweep done");
    mode = ADSQ_ONE_SHOT;
    ch = 3'h5;
    swp = 2'h0;
    tsel = 1; // far end keeps the trigger pin an input
    start = 1;
    step(40);
    `CHK(irq, 1'b0)
    fire = 1;
    step(4);
    fire = 0;
    wait_on(0);
    read(3'h5, d);
    `CHK(d, 10'h165)
    start = 0;
    tsel = 0;
    clear_irq();
    $display("test external trigger done");
    // repeat mode assumes an undivided cpu clock; reads still collide
    mode = ADSQ_REPEAT;
    ch = 3'h2;
    swp = 2'h0;
    start = 1;
    hits = 0;
    step(2);
    rsel = 3'h2;
    rd = 1;
    // stores land about 151 and 301 cycles after the start edge
    for (int i = 0; i < 320; i++) begin
      step(1);
      hits += (haz === 1'b1);
    end
    rd = 0;
    `CHK(hits, 2)
    // only repeat modes are aborted, so no interrupt mask is needed
    start = 0;
    step(3);
    `CHK({inv, busy}, 2'b10)
    $display("test repeat and abort done");
    // repeat sweep over channels 0 and 1 wraps back to channel 0
    mode = ADSQ_REPEAT_SWEEP0;
    ch = 3'h0;
    swp = 2'h0;
    start = 1;
    step(160);
    `CHK({sch, busy, inv}, 5'b00110)
    step(150);
    `CHK({sch, busy, inv}, 5'b00010)
    start = 0;
    step(3);
    `CHK({inv, busy}, 2'b10)
    $display("test repeat sweep done");
    key_en = 1;
    press = 1;
    wait_on(2);
    step(1);
    `CHK(key, 1'b0)
    press = 0;
    $display("test key input done");
    end_of_test();
  end
endmodule : adsq_ctrl_bench
`default_nettype wire
